// [core/wkt_pkg.sv]
// constants and carriers for the wake-up timer and timer 3 readback
package wkt_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_T3_RELOAD_HI = 6'h1f;
    localparam logic [5:0] IDX_T3_RELOAD_LO = 6'h20;
    localparam logic [5:0] IDX_T3_COUNT_HI = 6'h21;
    localparam logic [5:0] IDX_T3_COUNT_LO = 6'h22;
    localparam logic [5:0] IDX_WK_CONTROL = 6'h23;
    localparam logic [5:0] IDX_WK_RELOAD_HI = 6'h24;
    localparam logic [5:0] IDX_WK_RELOAD_LO = 6'h25;
    localparam logic [5:0] IDX_WK_COUNT_HI = 6'h26;
    localparam logic [5:0] IDX_WK_COUNT_LO = 6'h27;
    localparam logic [5:0] IDX_T3_START = 6'h30;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h32;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int CTL_RUN = 7;
    localparam int CTL_WEN = 6;
    localparam int CTL_TRIM = 5;
    localparam int CTL_CD = 4;
    localparam int CTL_AUTO = 3;
    localparam int CTL_WAKE = 2;
    localparam int ST_WK = 0;
    localparam int ST_CARD = 1;
    localparam int ST_T3 = 2;
    localparam logic [4:0] DIV1_LAST = 5'h00;
    localparam logic [4:0] DIV8_LAST = 5'h07;
    localparam logic [4:0] DIV16_LAST = 5'h0f;
    localparam logic [4:0] DIV32_LAST = 5'h1f;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {CD_IDLE, CD_FIELD} wkt_cd_t;

    typedef struct packed {
        logic trim_start;
        logic card_detect_start;
        logic wake_request;
        logic power_down_request;
    } wkt_evt_t;

    typedef struct packed {
        logic [1:0] osc_sync;
        logic osc_prev;
        logic [1:0] card_sync;
        logic [4:0] pre_cnt;
        logic running;
        logic trim_en;
        logic cd_en;
        logic auto_reload;
        logic auto_wake;
        logic [1:0] clk_sel;
        logic [15:0] wk_reload;
        logic [15:0] wk_count;
        logic [15:0] t3_reload;
        logic [15:0] t3_count;
        logic t3_run;
        wkt_cd_t cd_state;
        logic [2:0] status;
        logic [2:0] mask;
        logic aw_hold;
        logic [5:0] aw_idx;
        logic w_hold;
        logic [7:0] w_data;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        wkt_evt_t evt;
        logic irq;
    } wkt_state_t;

endpackage

// [core/wkt_wakeup_timer.sv]
// wake-up timer with timer 3 field window, behind an axi4-lite slave
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module wkt_wakeup_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic low_freq_oscillator,
    input wire logic card_present,
    output wkt_pkg::wkt_evt_t events,
    output logic rf_field_on,
    output logic irq
);

    if (ADDR_W < 8) begin : g_chk
        $error("ADDR_W must be at least 8");
    end

    wkt_pkg::wkt_state_t q;
    wkt_pkg::wkt_state_t next_q;

    logic osc_edge;
    logic [4:0] pre_last;
    logic wk_tick;
    logic wk_uf;
    logic t3_uf;
    logic t3_start;
    logic w_do;
    logic ar_fire;
    logic [5:0] ar_idx;
    logic [2:0] st_set;
    logic [2:0] st_clr;
    logic [7:0] rd_val;
    logic rd_ok;

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = ~q.aw_hold;
    assign s_axi_wready = ~q.w_hold;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = {24'h000000, q.rdata};
    assign events = q.evt;
    assign rf_field_on = q.t3_run & (q.cd_state == wkt_pkg::CD_FIELD);
    assign irq = q.irq;
    assign w_do = q.aw_hold & q.w_hold & ~q.bvalid;
    assign ar_fire = s_axi_arvalid & ~q.rvalid;
    assign ar_idx = s_axi_araddr[7:2];

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        rd_ok = 1'b1;
        if (ar_idx == wkt_pkg::IDX_T3_RELOAD_HI) begin
            rd_val = q.t3_reload[15:8];
        end else if (ar_idx == wkt_pkg::IDX_T3_RELOAD_LO) begin
            rd_val = q.t3_reload[7:0];
        end else if (ar_idx == wkt_pkg::IDX_T3_COUNT_HI) begin
            rd_val = q.t3_count[15:8];
        end else if (ar_idx == wkt_pkg::IDX_T3_COUNT_LO) begin
            rd_val = q.t3_count[7:0];
        end else if (ar_idx == wkt_pkg::IDX_WK_CONTROL) begin
            // write-enable bit always reads zero
            rd_val = {q.running, 1'b0, q.trim_en, q.cd_en, q.auto_reload,
                      q.auto_wake, q.clk_sel};
        end else if (ar_idx == wkt_pkg::IDX_WK_RELOAD_HI) begin
            rd_val = q.wk_reload[15:8];
        end else if (ar_idx == wkt_pkg::IDX_WK_RELOAD_LO) begin
            rd_val = q.wk_reload[7:0];
        end else if (ar_idx == wkt_pkg::IDX_WK_COUNT_HI) begin
            rd_val = q.wk_count[15:8];
        end else if (ar_idx == wkt_pkg::IDX_WK_COUNT_LO) begin
            rd_val = q.wk_count[7:0];
        end else if (ar_idx == wkt_pkg::IDX_T3_START) begin
            rd_val = {7'h00, q.t3_run};
        end else if (ar_idx == wkt_pkg::IDX_IRQ_STATUS) begin
            rd_val = {5'h00, q.status};
        end else if (ar_idx == wkt_pkg::IDX_IRQ_MASK) begin
            rd_val = {5'h00, q.mask};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // prescaler select
    // ------------------------------------------------------------
    always_comb begin
        case (q.clk_sel)
            2'h0: pre_last = wkt_pkg::DIV1_LAST;
            2'h1: pre_last = wkt_pkg::DIV8_LAST;
            2'h2: pre_last = wkt_pkg::DIV16_LAST;
            default: pre_last = wkt_pkg::DIV32_LAST;
        endcase
    end

    assign osc_edge = q.osc_sync[1] & ~q.osc_prev;
    assign wk_tick = osc_edge & (q.pre_cnt == pre_last);
    assign wk_uf = q.running & wk_tick & (q.wk_count == 16'h0000);
    assign t3_uf = q.t3_run & (q.t3_count == 16'h0000);
    assign t3_start = (w_do & q.w_lane & (q.aw_idx == wkt_pkg::IDX_T3_START) & q.w_data[0])
                      | (wk_uf & q.cd_en);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.evt = '0;
        st_set = 3'h0;
        st_clr = 3'h0;
        next_q.osc_sync = {q.osc_sync[0], low_freq_oscillator};
        next_q.osc_prev = q.osc_sync[1];
        next_q.card_sync = {q.card_sync[0], card_present};

        if (osc_edge) begin
            next_q.pre_cnt = (q.pre_cnt == pre_last) ? 5'h00 : q.pre_cnt + 5'h01;
        end

        // wake-up countdown
        if (q.running & wk_tick) begin
            if (wk_uf) begin
                st_set[wkt_pkg::ST_WK] = 1'b1;
                next_q.evt.trim_start = q.trim_en;
                next_q.evt.card_detect_start = q.cd_en;
                next_q.evt.wake_request = q.auto_wake;
                if (q.auto_reload | q.cd_en) begin
                    next_q.wk_count = q.wk_reload;
                end else begin
                    next_q.running = 1'b0;
                end
            end else begin
                next_q.wk_count = q.wk_count - 16'h0001;
            end
        end

        // timer 3 counts aclk cycles; field window ends at its underflow
        if (q.t3_run) begin
            if (t3_uf) begin
                next_q.t3_run = 1'b0;
                st_set[wkt_pkg::ST_T3] = 1'b1;
                if (q.cd_state == wkt_pkg::CD_FIELD) begin
                    next_q.cd_state = wkt_pkg::CD_IDLE;
                    if (q.card_sync[1]) begin
                        st_set[wkt_pkg::ST_CARD] = 1'b1;
                        next_q.evt.wake_request = 1'b1;
                    end else begin
                        next_q.evt.power_down_request = q.auto_wake;
                    end
                end
            end else begin
                next_q.t3_count = q.t3_count - 16'h0001;
            end
        end
        if (t3_start) begin
            next_q.t3_run = 1'b1;
            next_q.t3_count = q.t3_reload;
        end
        if (wk_uf & q.cd_en) begin
            next_q.cd_state = wkt_pkg::CD_FIELD;
        end

        // write channel capture, either order
        if (s_axi_awvalid & ~q.aw_hold) begin
            next_q.aw_hold = 1'b1;
            next_q.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid & ~q.w_hold) begin
            next_q.w_hold = 1'b1;
            next_q.w_data = s_axi_wdata[7:0];
            next_q.w_lane = s_axi_wstrb[0];
        end
        if (q.bvalid & s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end
        if (w_do) begin
            next_q.aw_hold = 1'b0;
            next_q.w_hold = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = wkt_pkg::RESP_OKAY;
            if (q.aw_idx == wkt_pkg::IDX_T3_RELOAD_HI) begin
                if (q.w_lane) next_q.t3_reload[15:8] = q.w_data;
            end else if (q.aw_idx == wkt_pkg::IDX_T3_RELOAD_LO) begin
                if (q.w_lane) next_q.t3_reload[7:0] = q.w_data;
            end else if (q.aw_idx == wkt_pkg::IDX_WK_CONTROL) begin
                if (q.w_lane) begin
                    next_q.trim_en = q.w_data[wkt_pkg::CTL_TRIM];
                    next_q.cd_en = q.w_data[wkt_pkg::CTL_CD];
                    next_q.auto_reload = q.w_data[wkt_pkg::CTL_AUTO];
                    next_q.auto_wake = q.w_data[wkt_pkg::CTL_WAKE];
                    next_q.clk_sel = q.w_data[1:0];
                    if (q.w_data[wkt_pkg::CTL_WEN]) begin
                        next_q.running = q.w_data[wkt_pkg::CTL_RUN];
                        next_q.wk_count = q.wk_reload;
                        next_q.pre_cnt = 5'h00;
                    end
                end
            end else if (q.aw_idx == wkt_pkg::IDX_WK_RELOAD_HI) begin
                if (q.w_lane) next_q.wk_reload[15:8] = q.w_data;
            end else if (q.aw_idx == wkt_pkg::IDX_WK_RELOAD_LO) begin
                if (q.w_lane) next_q.wk_reload[7:0] = q.w_data;
            end else if (q.aw_idx == wkt_pkg::IDX_IRQ_MASK) begin
                if (q.w_lane) next_q.mask = q.w_data[2:0];
            end else if (q.aw_idx == wkt_pkg::IDX_T3_START) begin
                next_q.bresp = wkt_pkg::RESP_OKAY;
            end else if ((q.aw_idx == wkt_pkg::IDX_T3_COUNT_HI)
                         | (q.aw_idx == wkt_pkg::IDX_T3_COUNT_LO)
                         | (q.aw_idx == wkt_pkg::IDX_WK_COUNT_HI)
                         | (q.aw_idx == wkt_pkg::IDX_WK_COUNT_LO)
                         | (q.aw_idx == wkt_pkg::IDX_IRQ_STATUS)) begin
                next_q.bresp = wkt_pkg::RESP_OKAY;
            end else begin
                next_q.bresp = wkt_pkg::RESP_SLVERR;
            end
        end

        // read channel; status read clears, a new event wins
        if (q.rvalid & s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (ar_fire) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = rd_val;
            next_q.rresp = rd_ok ? wkt_pkg::RESP_OKAY : wkt_pkg::RESP_SLVERR;
            if (ar_idx == wkt_pkg::IDX_IRQ_STATUS) begin
                st_clr = 3'h7;
            end
        end
        next_q.status = (q.status & ~st_clr) | st_set;
        next_q.irq = |(next_q.status & next_q.mask);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.wk_reload <= wkt_pkg::RELOAD_RST;
            q.t3_reload <= wkt_pkg::RELOAD_RST;
            q.mask <= wkt_pkg::MASK_RST;
            q.cd_state <= wkt_pkg::CD_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic ctl_wr;
    assign ctl_wr = w_do & q.w_lane & (q.aw_idx == wkt_pkg::IDX_WK_CONTROL);

    property p_t3_load;
        t3_start |=> q.t3_run && (q.t3_count == $past(q.t3_reload));
    endproperty
    a_t3_load: assert property (p_t3_load) else $error("timer 3 did not load reload");

    property p_t3_read;
        ar_fire && (ar_idx == wkt_pkg::IDX_T3_COUNT_HI)
            |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(q.t3_count[15:8]));
    endproperty
    a_t3_read: assert property (p_t3_read) else $error("timer 3 high byte wrong");

    property p_run_write;
        ctl_wr && q.w_data[wkt_pkg::CTL_WEN]
            |=> q.running == $past(q.w_data[wkt_pkg::CTL_RUN]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("running not written");

    property p_run_hold;
        ctl_wr && !q.w_data[wkt_pkg::CTL_WEN] && !wk_uf |=> $stable(q.running);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("running changed unqualified");

    property p_trim;
        wk_uf && q.trim_en |=> events.trim_start;
    endproperty
    a_trim: assert property (p_trim) else $error("trimming not launched");

    property p_cd;
        wk_uf && q.cd_en |=> events.card_detect_start && rf_field_on;
    endproperty
    a_cd: assert property (p_cd) else $error("card detection not launched");

    property p_card;
        t3_uf && (q.cd_state == wkt_pkg::CD_FIELD) && q.card_sync[1]
            |=> q.status[wkt_pkg::ST_CARD] && events.wake_request;
    endproperty
    a_card: assert property (p_card) else $error("card found not flagged");

    property p_nogap;
        wk_uf && q.cd_en && !ctl_wr |=> q.running && (q.wk_count == $past(q.wk_reload));
    endproperty
    a_nogap: assert property (p_nogap) else $error("no restart in card detect");

    property p_field;
        (q.cd_state == wkt_pkg::CD_FIELD) && t3_uf && !t3_start |=> !rf_field_on;
    endproperty
    a_field: assert property (p_field) else $error("field outlived timer 3");

    property p_stop;
        wk_uf && !q.auto_reload && !q.cd_en && !ctl_wr |=> !q.running;
    endproperty
    a_stop: assert property (p_stop) else $error("timer did not stop");

    property p_flag;
        wk_uf |=> q.status[wkt_pkg::ST_WK];
    endproperty
    a_flag: assert property (p_flag) else $error("underflow flag not set");

    property p_wake;
        wk_uf && q.auto_wake |=> events.wake_request;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on underflow");

    property p_dec;
        q.running && wk_tick && (q.wk_count != 16'h0000) && !ctl_wr
            |=> q.wk_count == $past(q.wk_count) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("count did not decrement");

    property p_t3_read_lo;
        ar_fire && (ar_idx == wkt_pkg::IDX_T3_COUNT_LO)
            |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(q.t3_count[7:0]));
    endproperty
    a_t3_read_lo: assert property (p_t3_read_lo) else $error("timer 3 low byte wrong");

    property p_t3_late;
        w_do && (q.aw_idx == wkt_pkg::IDX_T3_RELOAD_LO) && !q.t3_run && !t3_start
            |=> $stable(q.t3_count);
    endproperty
    a_t3_late: assert property (p_t3_late) else $error("t3 count moved on write");

    property p_wk_late;
        w_do && (q.aw_idx == wkt_pkg::IDX_WK_RELOAD_LO) && !(q.running && wk_tick)
            |=> $stable(q.wk_count);
    endproperty
    a_wk_late: assert property (p_wk_late) else $error("wake count moved on write");

    property p_prescale;
        q.running && osc_edge && (q.pre_cnt != pre_last) && !ctl_wr |=> $stable(q.wk_count);
    endproperty
    a_prescale: assert property (p_prescale) else $error("count moved between ticks");

    c_underflow: cover property (wk_uf ##[1:1000] wk_uf);
    c_trim: cover property (events.trim_start);
    c_card: cover property (events.card_detect_start ##[1:200] q.status[wkt_pkg::ST_CARD]);
    c_pd: cover property (events.power_down_request);

endmodule

// [tb/wkt_wakeup_timer_bench.sv]
// self-checking bench for the wake-up timer and timer 3 readback block
`timescale 1ns/1ps
module wkt_wakeup_timer_bench;
    // ------------------------------------------------------------
    // signals and register table rows
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [1:0] resp;
    } wkt_row_t;
    localparam int OSC_P = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic osc = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic card = 1'b0;
    wkt_pkg::wkt_evt_t ev;
    logic rf;
    logic irq;
    logic [5:0] obs;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int dv [4] = '{1, 8, 16, 32};
    wkt_row_t rows [10] = '{
        '{wkt_pkg::IDX_T3_RELOAD_HI, 8'ha5, 8'ha5, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_T3_RELOAD_LO, 8'h3c, 8'h3c, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_WK_RELOAD_HI, 8'h5a, 8'h5a, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_WK_RELOAD_LO, 8'hc3, 8'hc3, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_WK_CONTROL, 8'h7f, 8'h3f, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_WK_CONTROL, 8'h80, 8'h00, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_T3_COUNT_HI, 8'hff, 8'h00, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_T3_COUNT_LO, 8'hff, 8'h00, wkt_pkg::RESP_OKAY},
        '{wkt_pkg::IDX_IRQ_MASK, 8'h05, 8'h05, wkt_pkg::RESP_OKAY},
        '{6'h3f, 8'h11, 8'h00, wkt_pkg::RESP_SLVERR}
    };

    assign obs = {irq, rf, ev};

    wkt_wakeup_timer #(.ADDR_W(8)) i_wkt_wakeup_timer (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_freq_oscillator(osc),
        .card_present(card), .events(ev), .rf_field_on(rf), .irq(irq)
    );

    initial begin
        forever #50 aclk = ~aclk;
    end

    // oscillator with a period of OSC_P clock cycles
    always @(posedge aclk) begin
        osc_div <= osc_div + 2'h1;
        osc <= osc_div[1];
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_n(input int g, input int e);
        cmp_count++;
        if (g != e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d, output logic [1:0] r);
        logic ta, tw, tb, dn;
        dn = 1'b0;
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!dn) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            dn = tb;
        end
    endtask

    task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, dn;
        dn = 1'b0;
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!dn) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            dn = tr;
        end
    endtask

    // cycles until obs bit b shows level l, capped at lim
    task automatic wait_lvl(input int b, input logic l, input int lim, output int n);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (obs[b] !== l && n < lim);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [1:0] rs;
        int n;
        repeat (20) @(posedge aclk);
        chk({awready, wready, arready, irq, ev}, 8'he0);
        aresetn <= 1'b1;
        foreach (rows[k]) begin
            wr(rows[k].idx, rows[k].wd, rs);
            chk(rs, rows[k].resp);
            rd(rows[k].idx, v, rs);
            chk(v, rows[k].rd);
            chk(rs, rows[k].resp);
        end
        // timer 3 start, live readback, underflow
        wr(wkt_pkg::IDX_T3_RELOAD_LO, 8'h28, rs);
        wr(wkt_pkg::IDX_T3_RELOAD_HI, 8'h00, rs);
        rd(wkt_pkg::IDX_T3_COUNT_LO, v, rs);
        chk(v, 8'h00);
        wr(wkt_pkg::IDX_T3_START, 8'h01, rs);
        rd(wkt_pkg::IDX_T3_COUNT_LO, v, rs);
        chk_n(v < 32'h28 && v > 32'h18, 1);
        rd(wkt_pkg::IDX_T3_COUNT_HI, v, rs);
        chk(v, 8'h00);
        wait_lvl(5, 1'b1, 100, n);
        chk_n(n < 100, 1);
        rd(wkt_pkg::IDX_IRQ_STATUS, v, rs);
        chk(v, 8'h04);
        wr(wkt_pkg::IDX_T3_RELOAD_LO, 8'h10, rs);
        rd(wkt_pkg::IDX_T3_COUNT_LO, v, rs);
        chk(v, 8'h00);
        rd(wkt_pkg::IDX_IRQ_STATUS, v, rs);
        chk(v, 32'h0);
        chk(irq, 1'b0);
        // one-shot wake-up count
        wr(wkt_pkg::IDX_WK_RELOAD_HI, 8'h00, rs);
        wr(wkt_pkg::IDX_WK_RELOAD_LO, 8'h02, rs);
        wr(wkt_pkg::IDX_WK_CONTROL, 8'hc0, rs);
        rd(wkt_pkg::IDX_WK_CONTROL, v, rs);
        chk(v, 8'h80);
        wait_lvl(5, 1'b1, 100, n);
        chk_n(n < 100, 1);
        rd(wkt_pkg::IDX_WK_CONTROL, v, rs);
        chk(v, 8'h00);
        rd(wkt_pkg::IDX_IRQ_STATUS, v, rs);
        chk(v, 8'h01);
        repeat (2) @(posedge aclk);
        wait_lvl(5, 1'b1, 60, n);
        chk_n(n, 60);
        // auto reload period per clock select, trim and wake pulses
        for (int s = 0; s < 4; s++) begin
            wr(wkt_pkg::IDX_WK_CONTROL, 8'hec | s[7:0], rs);
            wait_lvl(1, 1'b1, 2000, n);
            wait_lvl(1, 1'b1, 2000, n);
            chk_n(n, 3 * OSC_P * dv[s]);
            wait_lvl(3, 1'b1, 2000, n);
            wait_lvl(3, 1'b1, 2000, n);
            chk_n(n, 3 * OSC_P * dv[s]);
        end
        wr(wkt_pkg::IDX_WK_CONTROL, 8'h0f, rs);
        rd(wkt_pkg::IDX_WK_CONTROL, v, rs);
        chk(v, 8'h8f);
        // auto wake kept on so a timer that failed to stop would pulse
        wr(wkt_pkg::IDX_WK_CONTROL, 8'h44, rs);
        rd(wkt_pkg::IDX_WK_CONTROL, v, rs);
        chk(v, 8'h04);
        wait_lvl(1, 1'b1, 500, n);
        chk_n(n, 500);
        // card detection with timer 3 field window
        wr(wkt_pkg::IDX_T3_RELOAD_LO, 8'h05, rs);
        wr(wkt_pkg::IDX_IRQ_MASK, 8'h02, rs);
        rd(wkt_pkg::IDX_IRQ_STATUS, v, rs);
        wr(wkt_pkg::IDX_WK_CONTROL, 8'hd4, rs);
        wait_lvl(2, 1'b1, 100, n);
        wait_lvl(2, 1'b1, 100, n);
        chk_n(n, 3 * OSC_P);
        // field rises with the launch pulse, counted from that cycle
        chk(rf, 1'b1);
        wait_lvl(4, 1'b0, 100, n);
        chk_n(n, 6);
        wait_lvl(0, 1'b1, 100, n);
        chk_n(n < 100, 1);
        chk(irq, 1'b0);
        @(posedge aclk);
        card <= 1'b1;
        wait_lvl(5, 1'b1, 100, n);
        chk_n(n < 100, 1);
        rd(wkt_pkg::IDX_IRQ_STATUS, v, rs);
        chk(v & 32'h2, 32'h2);
        // second reset in mid-run
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(wkt_pkg::IDX_WK_RELOAD_HI, v, rs);
        chk(v, 8'h00);
        rd(wkt_pkg::IDX_WK_CONTROL, v, rs);
        chk(v, 8'h00);
        chk(irq, 1'b0);
        print_verdict();
    end
endmodule
